/* verilog/hps_pin_select.sv */
// Host port pin function select with APB register access
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "hps_regs.svh"
module hps_pin_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`HPS_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hps_pkg::hps_pins_t port_pin_i,
  output hps_pkg::hps_pins_t port_pin_o,
  output hps_pkg::hps_pins_t port_pin_oe,
  input wire hps_pkg::hps_byte_t hi_data_out,
  input wire logic hi_data_oe,
  output hps_pkg::hps_byte_t hi_data_in,
  output hps_pkg::hps_addr3_t hi_addr_lo,
  output hps_pkg::hps_addr3_t hi_addr_hi,
  output logic hi_addr_strobe,
  output logic hi_select,
  output logic hi_dir,
  output logic hi_read_strobe,
  output logic hi_write_strobe,
  output logic hi_single_strobe,
  output hps_pkg::hps_mode_e hi_mode
);
  import hps_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`HPS_PCR_W-1:0] pcr_r;
  hps_pins_t ddr_r;
  hps_pins_t dat_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  hps_pins_t pin_in;
  hps_pins_t host_use;
  hps_pins_t host_drive;
  hps_pins_t host_val;
  hps_pins_t gpio_rd;
  hps_mode_e mode;
  logic host_en;
  logic is_mux;
  logic is_dbl;
  logic en_nonmux;
  logic en_mux;
  logic en_single;
  logic en_double;
  logic wr_en;
  logic setup;
  logic hit;
  logic [31:0] rd_val;
  logic [15:0] sts;

  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;

  // ----------------------------------------------------------------
  // Pin map
  // ----------------------------------------------------------------
  // Pin   General   Non-multiplexed host   Multiplexed host
  // 0-7   port bit  data bus               shared address/data bus
  // 8     port bit  address line 0         address strobe
  // 9     port bit  address line 1         address line 8
  // 10    port bit  address line 2         address line 9
  // 11    port bit  direction, or read strobe on a double-strobe bus
  // 12    port bit  data strobe, or write strobe on a double-strobe bus
  // 13    port bit  chip select            address line 10
  // General mode gives every pin its own direction bit; host mode
  // drives the data pins from hi_data_oe and keeps every other pin an input.
  // One polarity bit serves all three data strobes: fewer control
  // bits, but a host with mixed strobe polarities cannot be matched.

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign host_en = pcr_r[`HPS_PCR_HEN];
  assign is_mux = pcr_r[`HPS_PCR_MUX];
  assign is_dbl = pcr_r[`HPS_PCR_DBL];

  always_comb begin
    case ({host_en, is_mux})
      2'b10: mode = HPS_MODE_NONMUX;
      2'b11: mode = HPS_MODE_MUX;
      default: mode = HPS_MODE_GPIO;
    endcase
  end

  assign en_nonmux = (mode == HPS_MODE_NONMUX);
  assign en_mux = (mode == HPS_MODE_MUX);
  assign en_single = host_en & ~is_dbl;
  assign en_double = host_en & is_dbl;
  assign hi_mode = mode;

  // ----------------------------------------------------------------
  // Per-pin ownership
  // ----------------------------------------------------------------
  // Host mode owns all pins; the control pins are inputs only, so
  // a host driving them can never fight the device.
  always_comb begin
    host_use = {`HPS_NPINS{host_en}};
    host_drive = '0;
    host_val = '0;
    host_drive[`HPS_PIN_D7:`HPS_PIN_D0] = {8{hi_data_oe}};
    host_val[`HPS_PIN_D7:`HPS_PIN_D0] = hi_data_out;
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // Every pad passes one flop each way, so a decoded host line lags
  // its pin by one edge and the host data byte by two.
  genvar gi;
  generate
    for (gi = 0; gi < `HPS_NPINS; gi = gi + 1) begin : g_pin
      hps_pin_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .host_use(host_use[gi]),
        .host_drive(host_drive[gi]),
        .host_val(host_val[gi]),
        .gpio_out_en(ddr_r[gi]),
        .gpio_val(dat_r[gi]),
        .pad_i(port_pin_i[gi]),
        .pad_o_r(port_pin_o[gi]),
        .pad_oe_r(port_pin_oe[gi]),
        .pad_in_r(pin_in[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host data and address
  // ----------------------------------------------------------------
  // Data pins read as zero outside host mode so the transfer logic
  // never sees general-purpose traffic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_data_in <= 8'h00;
    end else if (host_en) begin
      hi_data_in <= pin_in[`HPS_PIN_D7:`HPS_PIN_D0];
    end else begin
      hi_data_in <= 8'h00;
    end
  end

  always_comb begin
    hi_addr_lo = 3'h0;
    hi_addr_hi = 3'h0;
    if (en_nonmux) begin
      hi_addr_lo[0] = pin_in[`HPS_PIN_A0];
      hi_addr_lo[1] = pin_in[`HPS_PIN_A1];
      hi_addr_lo[2] = pin_in[`HPS_PIN_A2];
    end
    if (en_mux) begin
      hi_addr_hi[0] = pin_in[`HPS_PIN_A1];
      hi_addr_hi[1] = pin_in[`HPS_PIN_A2];
      hi_addr_hi[2] = pin_in[`HPS_PIN_SEL];
    end
  end

  // ----------------------------------------------------------------
  // Strobes and select
  // ----------------------------------------------------------------
  hps_strobe_in u_as (
    .raw(pin_in[`HPS_PIN_A0]),
    .pol_high(pcr_r[`HPS_PCR_ASP]),
    .enable(en_mux),
    .active(hi_addr_strobe)
  );

  hps_strobe_in u_sel (
    .raw(pin_in[`HPS_PIN_SEL]),
    .pol_high(pcr_r[`HPS_PCR_CSP]),
    .enable(en_nonmux),
    .active(hi_select)
  );

  hps_strobe_in u_rd (
    .raw(pin_in[`HPS_PIN_DIR]),
    .pol_high(pcr_r[`HPS_PCR_DSP]),
    .enable(en_double),
    .active(hi_read_strobe)
  );

  hps_strobe_in u_wr (
    .raw(pin_in[`HPS_PIN_STB]),
    .pol_high(pcr_r[`HPS_PCR_DSP]),
    .enable(en_double),
    .active(hi_write_strobe)
  );

  hps_strobe_in u_ds (
    .raw(pin_in[`HPS_PIN_STB]),
    .pol_high(pcr_r[`HPS_PCR_DSP]),
    .enable(en_single),
    .active(hi_single_strobe)
  );

  // Direction is a plain level, high for a host read
  assign hi_dir = en_single & pin_in[`HPS_PIN_DIR];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reset leaves every polarity bit clear, i.e. active-low strobes.
  // Reserved control bits are forced to zero so they read back 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcr_r <= `HPS_PCR_RST;
    end else if (wr_en && paddr == `HPS_PCR_OFF) begin
      pcr_r <= '0;
      pcr_r[`HPS_PCR_CSP:`HPS_PCR_HEN] <=
        pwdata[`HPS_PCR_CSP:`HPS_PCR_HEN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddr_r <= `HPS_DDR_RST;
    end else if (wr_en && paddr == `HPS_DDR_OFF) begin
      ddr_r <= pwdata[`HPS_NPINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_r <= `HPS_DAT_RST;
    end else if (wr_en && paddr == `HPS_DAT_OFF) begin
      dat_r <= pwdata[`HPS_NPINS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Output pins read back the driven value, inputs read the pad.
  assign gpio_rd = (ddr_r & dat_r) | (~ddr_r & pin_in);

  // Status packs the decoded host lines so software can watch a
  // host transfer without probing the pads.
  always_comb begin
    sts = 16'h0000;
    sts[`HPS_STS_AHI-1:`HPS_STS_ALO] = hi_addr_lo;
    sts[`HPS_STS_AS-1:`HPS_STS_AHI] = hi_addr_hi;
    sts[`HPS_STS_AS] = hi_addr_strobe;
    sts[`HPS_STS_SEL] = hi_select;
    sts[`HPS_STS_DIR] = hi_dir;
    sts[`HPS_STS_RD] = hi_read_strobe;
    sts[`HPS_STS_WR] = hi_write_strobe;
    sts[`HPS_STS_DS] = hi_single_strobe;
    sts[`HPS_STS_MODE+2:`HPS_STS_MODE] = mode;
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `HPS_PCR_OFF: rd_val[`HPS_PCR_W-1:0] = pcr_r;
      `HPS_DDR_OFF: rd_val[`HPS_NPINS-1:0] = ddr_r;
      `HPS_DAT_OFF: rd_val[`HPS_NPINS-1:0] = gpio_rd;
      `HPS_STS_OFF: rd_val[15:0] = sts;
      default: hit = 1'b0;
    endcase
  end

  // Read data and error are caught in the setup cycle, so the access
  // phase always completes in one cycle with stable outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= ~hit;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;
  assign pready = 1'b1;
endmodule : hps_pin_select

/* pkg/hps_regs.svh */
// Register offsets, field positions, pin map and reset values
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
`define HPS_NPINS 14
`define HPS_ADDR_W 12
`define HPS_PCR_OFF 12'h000
`define HPS_DDR_OFF 12'h004
`define HPS_DAT_OFF 12'h008
`define HPS_STS_OFF 12'h00c
`define HPS_PCR_W 16
`define HPS_PCR_RST 16'h0000
`define HPS_DDR_RST 14'h0000
`define HPS_DAT_RST 14'h0000
`define HPS_PCR_HEN 0
`define HPS_PCR_MUX 1
`define HPS_PCR_DBL 2
`define HPS_PCR_DSP 3
`define HPS_PCR_ASP 4
`define HPS_PCR_CSP 5
`define HPS_PIN_D0 0
`define HPS_PIN_D7 7
`define HPS_PIN_A0 8
`define HPS_PIN_A1 9
`define HPS_PIN_A2 10
`define HPS_PIN_DIR 11
`define HPS_PIN_STB 12
`define HPS_PIN_SEL 13
`define HPS_STS_ALO 0
`define HPS_STS_AHI 3
`define HPS_STS_AS 6
`define HPS_STS_SEL 7
`define HPS_STS_DIR 8
`define HPS_STS_RD 9
`define HPS_STS_WR 10
`define HPS_STS_DS 11
`define HPS_STS_MODE 12
`endif

/* pkg/hps_pkg.sv */
// Types shared by the host port pin function select block
package hps_pkg;
`include "hps_regs.svh"
  typedef logic [`HPS_NPINS-1:0] hps_pins_t;
  typedef logic [7:0] hps_byte_t;
  typedef logic [2:0] hps_addr3_t;
  typedef enum logic [2:0] {
    HPS_MODE_GPIO = 3'b001,
    HPS_MODE_NONMUX = 3'b010,
    HPS_MODE_MUX = 3'b100
  } hps_mode_e;
endpackage : hps_pkg

/* verilog/hps_pin_cell.sv */
// One port pin: chooses host or general-purpose drive, registers pad
`timescale 1ns/1ns
module hps_pin_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_use,
  input wire logic host_drive,
  input wire logic host_val,
  input wire logic gpio_out_en,
  input wire logic gpio_val,
  input wire logic pad_i,
  output logic pad_o_r,
  output logic pad_oe_r,
  output logic pad_in_r
);
  // ----------------------------------------------------------------
  // Pad drive and capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_o_r <= 1'b0;
      pad_oe_r <= 1'b0;
      pad_in_r <= 1'b0;
    end else begin
      pad_oe_r <= host_use ? host_drive : gpio_out_en;
      pad_o_r <= host_use ? host_val : gpio_val;
      pad_in_r <= pad_i;
    end
  end
endmodule : hps_pin_cell

/* verilog/hps_strobe_in.sv */
// Polarity-programmable strobe input, normalised to active high
`timescale 1ns/1ns
module hps_strobe_in (
  input wire logic raw,
  input wire logic pol_high,
  input wire logic enable,
  output logic active
);
  // Polarity bit low means the pin is asserted when low
  assign active = enable & (pol_high ? raw : ~raw);
endmodule : hps_strobe_in

/* dv/hps_pin_select_sva.sv */
// Port checker for the host port pin function select
`timescale 1ns/1ns
module hps_pin_select_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire hps_pkg::hps_pins_t port_pin_i,
  input wire hps_pkg::hps_pins_t port_pin_o,
  input wire hps_pkg::hps_pins_t port_pin_oe,
  input wire hps_pkg::hps_byte_t hi_data_out,
  input wire logic hi_data_oe,
  input wire hps_pkg::hps_byte_t hi_data_in,
  input wire hps_pkg::hps_addr3_t hi_addr_lo,
  input wire hps_pkg::hps_addr3_t hi_addr_hi,
  input wire logic hi_addr_strobe,
  input wire logic hi_select,
  input wire logic hi_dir,
  input wire logic hi_read_strobe,
  input wire logic hi_write_strobe,
  input wire logic hi_single_strobe,
  input wire hps_pkg::hps_mode_e hi_mode
);
  import hps_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_nmx; hi_mode == HPS_MODE_NONMUX; endsequence
  sequence s_mux; hi_mode == HPS_MODE_MUX; endsequence
  // Three host cycles cover the pad flop plus the data register
  sequence s_host; (hi_mode != HPS_MODE_GPIO) [*3]; endsequence
  gpio_quiet_a: assert property (hi_mode == HPS_MODE_GPIO |->
    {hi_addr_lo, hi_addr_hi, hi_addr_strobe, hi_select, hi_dir,
     hi_read_strobe, hi_write_strobe, hi_single_strobe} == '0)
    else $error("host lines active in gpio mode");
  nmx_addr_a: assert property (s_nmx |-> hi_addr_hi == 0 &&
    hi_addr_lo == $past(port_pin_i[10:8])) else $error("nonmux addr");
  mux_addr_a: assert property (s_mux |-> hi_addr_lo == 0 &&
    hi_addr_hi == {$past(port_pin_i[13]), $past(port_pin_i[10:9])})
    else $error("mux addr");
  mux_nosel_a: assert property (s_mux |-> !hi_select)
    else $error("select in mux mode");
  nmx_noas_a: assert property (s_nmx |-> !hi_addr_strobe)
    else $error("addr strobe in nonmux mode");
  dbl_excl_a: assert property (hi_read_strobe || hi_write_strobe |->
    !hi_single_strobe && !hi_dir) else $error("strobe styles mixed");
  dir_pin_a: assert property (hi_dir |-> $past(port_pin_i[11]))
    else $error("dir without pin level");
  data_in_a: assert property (s_host |->
    hi_data_in == $past(port_pin_i[7:0], 2)) else $error("data in");
  host_drive_a: assert property (s_host ##0 $past(hi_data_oe) |->
    port_pin_oe == 14'h00ff && port_pin_o[7:0] == $past(hi_data_out))
    else $error("host data drive");
  host_float_a: assert property (s_host ##0 !$past(hi_data_oe) |->
    port_pin_oe == 0) else $error("pad driven in host mode");
endmodule : hps_pin_select_sva

/* dv/hps_host_model.sv */
// Behavioural external host that drives the port pads
`timescale 1ns/1ns
module hps_host_model (
  input wire logic pclk,
  input wire logic act,
  input wire logic mux,
  input wire logic dbl,
  input wire logic wr,
  input wire logic [2:0] pol,
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  output hps_pkg::hps_pins_t pins
);
  logic [7:0] jk = 8'h5a;
  logic ds, as, cs;
  assign {cs, as, ds} = pol;
  initial pins = '0;
  // Released lines rotate so a stale value never passes for data
  always @(posedge pclk) begin
    jk <= ~{jk[6:0], jk[7]};
    if (!act)
      pins <= {mux ? jk[2] : ~cs, ~ds, dbl ? ~ds : jk[0], jk[4:3],
               mux ? ~as : jk[1], jk};
    else
      pins <= {mux ? addr[10] : cs, dbl & !wr ? ~ds : ds,
               dbl ? (wr ? ~ds : ds) : ~wr,
               mux ? {addr[9:8], as} : addr[2:0],
               wr ? wdata : (mux ? addr[7:0] : jk)};
  end
endmodule : hps_host_model

/* dv/hps_pin_select_bench.sv */
// Self-checking bench for the host port pin function select
`timescale 1ns/1ns
`include "hps_regs.svh"
module hps_pin_select_bench;
  import hps_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, hi_data_oe = 0, act = 0, mux = 0, dbl = 0, wr = 0;
  logic hi_addr_strobe, hi_select, hi_dir, hi_read_strobe;
  logic hi_write_strobe, hi_single_strobe;
  logic [2:0] pol = 0;
  logic [10:0] haddr = 0;
  logic [22:0] dec;
  hps_pins_t port_pin_i, port_pin_o, port_pin_oe, host_pins;
  hps_byte_t hi_data_out = 0, hi_data_in;
  hps_addr3_t hi_addr_lo, hi_addr_hi;
  hps_mode_e hi_mode;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 pclk = ~pclk;
  assign port_pin_i = port_pin_oe & port_pin_o | ~port_pin_oe & host_pins;
  assign dec = {hi_mode, hi_addr_lo, hi_addr_hi, hi_addr_strobe, hi_select,
    hi_dir, hi_read_strobe, hi_write_strobe, hi_single_strobe, hi_data_in};
  hps_pin_select u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .port_pin_i, .port_pin_o,
    .port_pin_oe, .hi_data_out, .hi_data_oe, .hi_data_in, .hi_addr_lo,
    .hi_addr_hi, .hi_addr_strobe, .hi_select, .hi_dir, .hi_read_strobe,
    .hi_write_strobe, .hi_single_strobe, .hi_mode);
  hps_host_model u_host (.pclk, .act, .mux, .dbl, .wr, .pol, .addr(haddr),
    .wdata(8'hc6), .pins(host_pins));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Host transfer in mode m/d with polarity p, then idle bus
  task hx(input logic m, d, w, input logic [2:0] p, input logic [10:0] a);
    logic [22:0] mk;
    mux <= m;
    dbl <= d;
    wr <= w;
    pol <= p;
    haddr <= a;
    act <= 1;
    apb(1, `HPS_PCR_OFF, {26'h0, p, d, m, 1'b1});
    repeat (4) @(posedge pclk);
    mk = m | w ? 23'h7fffff : 23'h7fff00;
    chk(dec & mk, mk & {m ? HPS_MODE_MUX : HPS_MODE_NONMUX,
      m ? 3'b0 : a[2:0], m ? a[10:8] : 3'b0, m, !m, !d & !w,
      d & !w, d & w, !d, w ? 8'hc6 : a[7:0]});
    act <= 0;
    repeat (4) @(posedge pclk);
    chk({hi_addr_strobe, hi_select, hi_read_strobe, hi_write_strobe,
      hi_single_strobe}, 0);
  endtask : hx
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    apb(0, `HPS_PCR_OFF, 0);
    chk(rd, 0);
    apb(0, `HPS_STS_OFF, 0);
    chk(rd, 32'h1000);
    apb(1, 12'h010, 32'h3f);
    chk({31'h0, err}, 32'h1);
    apb(0, 12'h010, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 0);
    apb(0, `HPS_PCR_OFF, 0);
    chk({31'h0, err}, 32'h0);
    chk(rd, 0);
    $display("reset values done");
  endtask : t_regs
  task t_gpio();
    act <= 1;
    wr <= 1;
    haddr <= 11'h006;
    apb(1, `HPS_DDR_OFF, 32'h0f0f);
    apb(1, `HPS_DAT_OFF, 32'h3333);
    repeat (2) @(posedge pclk);
    chk(port_pin_oe, 14'h0f0f);
    chk(port_pin_o & 14'h0f0f, 14'h0303);
    chk(dec, 23'h100000);
    apb(0, `HPS_DAT_OFF, 0);
    chk(rd, 14'h0303 | host_pins & 14'h30f0);
    $display("gpio done");
  endtask : t_gpio
  task t_nonmux();
    hx(0, 0, 1, 3'b000, 11'h005);
    hx(0, 0, 0, 3'b111, 11'h002);
    hx(0, 1, 0, 3'b001, 11'h006);
    hx(0, 1, 1, 3'b000, 11'h001);
    $display("nonmux done");
  endtask : t_nonmux
  task t_mux();
    hx(1, 0, 0, 3'b010, 11'h5a3);
    hx(1, 1, 1, 3'b101, 11'h2c6);
    hi_data_oe <= 1;
    hi_data_out <= 8'hc3;
    repeat (3) @(posedge pclk);
    chk(port_pin_oe, 14'h00ff);
    chk(port_pin_o[7:0], 8'hc3);
    hi_data_oe <= 0;
    $display("mux done");
  endtask : t_mux
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_gpio();
    t_nonmux();
    t_mux();
    give_verdict();
  end
endmodule : hps_pin_select_bench
bind hps_pin_select hps_pin_select_sva u_sva (.pclk, .presetn, .port_pin_i,
  .port_pin_o, .port_pin_oe, .hi_data_out, .hi_data_oe, .hi_data_in,
  .hi_addr_lo, .hi_addr_hi, .hi_addr_strobe, .hi_select, .hi_dir,
  .hi_read_strobe, .hi_write_strobe, .hi_single_strobe, .hi_mode);
